// *** rtl/sao_pkg.sv ***
package sao_pkg;
  // sample word and slot layout
  localparam int SAMPLE_W = 24;
  localparam int SLOT_BITS = 32;
  localparam int FRAME_BITS = 2 * SLOT_BITS;
  // format and filter pin encodings
  localparam logic FMT_I2S = 1'h0;
  localparam logic FMT_LJ = 1'h1;
  localparam logic HPF_ON = 1'h0;
  // pole 1 - 2^-11 = 0.99951, nearest shift form of 0.9995
  localparam real HPF_POLE = 0.9995;
  localparam int HPF_SHIFT = 11;
  // master clock to frame ratio detection
  localparam int RATIO_W = 11;
  localparam logic [3:0][RATIO_W-1:0] MCLK_RATIOS = {11'h300, 11'h200, 11'h180, 11'h100};
  localparam logic [RATIO_W-1:0] RATIO_TOL = 11'h020;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 11'h7FF;
  // master clock stop detection, least time rounds up
  localparam int CLK_PERIOD_NS = 40;
  localparam int MCLK_STOP_US = 10;
  localparam int MCLK_STOP_CYC = (MCLK_STOP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_W = $clog2(MCLK_STOP_CYC + 1);
  // receiver sampling point lag behind its own bit clock rise
  localparam int SYNC_LAT = 2;
endpackage

// *** rtl/sao_if.sv ***
`timescale 1ns/1ns
interface sao_if;
  logic audio_mclk;
  logic bclk;
  logic lrclk;
  logic serial_sample_out;
  modport dev (
    input audio_mclk,
    input bclk,
    input lrclk,
    output serial_sample_out
  );
  modport rcv (
    output audio_mclk,
    output bclk,
    output lrclk,
    input serial_sample_out
  );
endinterface

// *** rtl/sao_rx.sv ***
`timescale 1ns/1ns
module sao_rx #(
  parameter int BCLK_DIV = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  sao_if.rcv link,
  input wire logic audio_clk_run,
  input wire logic format_select,
  output logic [sao_pkg::SAMPLE_W-1:0] rx_left,
  output logic [sao_pkg::SAMPLE_W-1:0] rx_right,
  output logic rx_valid
);
  import sao_pkg::*;

  localparam int PH_W = $clog2(BCLK_DIV);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(BCLK_DIV - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(BCLK_DIV / 2);
  localparam logic [PH_W-1:0] PH_TAKE = PH_W'(BCLK_DIV / 2 + SYNC_LAT);
  localparam int BI_W = $clog2(FRAME_BITS);
  localparam int OFF_W = $clog2(SLOT_BITS);
  localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(SAMPLE_W - 1);

  typedef struct packed {
    logic amclk;
    logic bclk;
    logic lrclk;
    logic [PH_W-1:0] phase;
    logic [BI_W-1:0] bit_idx;
    logic [1:0] sd_s;
    logic [SAMPLE_W-1:0] shift;
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] out_left;
    logic [SAMPLE_W-1:0] out_right;
    logic valid;
  } sao_rx_s;

  sao_rx_s r_reg;
  sao_rx_s r_next;

  always_comb begin
    logic [OFF_W-1:0] off;
    logic [SAMPLE_W-1:0] sh;
    off = '0;
    sh = '0;
    r_next = r_reg;
    r_next.valid = 1'b0;
    r_next.sd_s = {r_reg.sd_s[0], link.serial_sample_out};
    if (audio_clk_run) begin
      r_next.amclk = ~r_reg.amclk;
    end
    // bit and frame clocks follow a free counter
    if (r_reg.phase == PH_LAST) begin
      r_next.phase = '0;
      r_next.bit_idx = r_reg.bit_idx + 1'b1;
    end else begin
      r_next.phase = r_reg.phase + 1'b1;
    end
    r_next.bclk = (r_next.phase >= PH_HALF);
    // R14 R16
    r_next.lrclk = (format_select == FMT_LJ) ? ~r_next.bit_idx[BI_W-1] : r_next.bit_idx[BI_W-1];
    // sample shortly after own rising edge
    if (r_reg.phase == PH_TAKE) begin
      // R13 R15
      off = r_reg.bit_idx[OFF_W-1:0] - ((format_select == FMT_I2S) ? 1'b1 : 1'b0);
      sh = {r_reg.shift[SAMPLE_W-2:0], r_reg.sd_s[1]};
      if (off <= OFF_LAST) begin
        r_next.shift = sh;
      end
      if (off == OFF_LAST) begin
        if (!r_reg.bit_idx[BI_W-1]) begin
          r_next.left = sh;
        end else begin
          r_next.out_left = r_reg.left;
          r_next.out_right = sh;
          r_next.valid = 1'b1;
        end
      end
    end
    // audio clock keeps running in reset so the far end can reset too
    if (!nrst) begin
      r_next = '0;
      r_next.amclk = audio_clk_run & ~r_reg.amclk;
    end
  end

  always_ff @(posedge mclk) begin
    r_reg <= r_next;
  end

  // R3 R6
  assign link.audio_mclk = r_reg.amclk;
  assign link.bclk = r_reg.bclk;
  assign link.lrclk = r_reg.lrclk;
  assign rx_left = r_reg.out_left;
  assign rx_right = r_reg.out_right;
  assign rx_valid = r_reg.valid;
endmodule

// *** rtl/sao_adc_out.sv ***
`timescale 1ns/1ns
// Operation
// R1: samples before ready are discarded
// R2: reset leaves every register at default; code keeps link synchronizers sampling in reset
// R3: master clock is 256/384/512/768 fs
// R4: ratio detected within 32 master clocks; code checks it once per frame, at each frame clock rise
// R5: bad ratio freezes output at last value
// R6: master clock kept synchronous to frame clock
// R7: master clock stop over 10us: low power
// R8: filter bypass pin selects high-pass filter
// R9: high-pass pole coefficient 0.9995, zero at DC
// R10: format pin: 0 I2S, 1 left-justified
// R11: samples shifted out MSB first
// R12: channels interleaved, frame clock marks channel
// R13: left-justified MSB on frame-change falling edge
// R14: left-justified: frame high left, low right
// R15: I2S MSB one falling edge after change
// R16: I2S: frame low left, high right
// R17: samples processed at 24-bit resolution
// R18: slot bits after LSB driven low
module sao_adc_out (
  input wire logic mclk,
  input wire logic nrst,
  sao_if.dev link,
  input wire logic hpf_bypass_sel,
  input wire logic format_select,
  input wire logic sample_valid,
  input wire logic [sao_pkg::SAMPLE_W-1:0] sample_left,
  input wire logic [sao_pkg::SAMPLE_W-1:0] sample_right,
  output logic sample_ready,
  output logic power_good_n,
  output logic ref_power_down,
  output logic ratio_error
);
  import sao_pkg::*;

  localparam int ACC_W = SAMPLE_W + 2;
  localparam logic [SAMPLE_W-1:0] POS_FULL = {1'h0, {(SAMPLE_W - 1){1'h1}}};
  localparam logic [SAMPLE_W-1:0] NEG_FULL = {1'h1, {(SAMPLE_W - 1){1'h0}}};
  localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(MCLK_STOP_CYC - 1);

  // core side, on mclk
  typedef struct packed {
    logic ready;
    logic [1:0] byp_s;
    logic [1:0][SAMPLE_W-1:0] x_prev;
    logic [1:0][SAMPLE_W-1:0] y;
    logic req;
    logic [1:0] ack_s;
    logic [2:0] beat_s;
    logic [STOP_W-1:0] idle_cnt;
    logic low_power;
    logic [1:0] ok_s;
  } sao_core_s;

  // link side, on the master clock pin
  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] fmt_s;
    logic [2:0] bclk_s;
    logic [2:0] lr_s;
    logic [2:0] req_s;
    logic fall_d;
    logic lr_prev;
    logic [1:0][SAMPLE_W-1:0] pair;
    logic [SAMPLE_W-1:0] word;
    logic ack;
    logic beat;
    logic [RATIO_W-1:0] frame_cnt;
    logic ratio_ok;
    logic sdo;
  } sao_link_s;

  sao_core_s c_reg;
  sao_core_s c_next;
  sao_link_s l_reg;
  sao_link_s l_next;

  logic busy;
  assign busy = (c_reg.req != c_reg.ack_s[1]);

  always_comb begin
    logic signed [SAMPLE_W-1:0] xin;
    logic signed [SAMPLE_W-1:0] yold;
    logic signed [ACC_W-1:0] acc;
    xin = '0;
    yold = '0;
    acc = '0;
    c_next = c_reg;
    c_next.ready = 1'b1;
    c_next.byp_s = {c_reg.byp_s[0], hpf_bypass_sel};
    c_next.ack_s = {c_reg.ack_s[0], l_reg.ack};
    c_next.beat_s = {c_reg.beat_s[1:0], l_reg.beat};
    c_next.ok_s = {c_reg.ok_s[0], l_reg.ratio_ok};
    // R1
    if (sample_valid && c_reg.ready && !busy) begin
      for (int ch = 0; ch < 2; ch++) begin
        xin = (ch == 0) ? sample_left : sample_right;
        yold = $signed(c_reg.y[ch]);
        // R9 R17
        acc = ACC_W'(xin) - ACC_W'($signed(c_reg.x_prev[ch])) + ACC_W'(yold)
            - ACC_W'(yold >>> HPF_SHIFT);
        c_next.x_prev[ch] = xin;
        if (c_reg.byp_s[1] != HPF_ON) begin
          c_next.y[ch] = xin; // R8
        end else if (acc[ACC_W-1:SAMPLE_W-1] == '0 || acc[ACC_W-1:SAMPLE_W-1] == '1) begin
          c_next.y[ch] = acc[SAMPLE_W-1:0]; // R8
        end else begin
          c_next.y[ch] = acc[ACC_W-1] ? NEG_FULL : POS_FULL;
        end
      end
      c_next.req = ~c_reg.req;
    end
    // master clock watchdog
    if (c_reg.beat_s[2] != c_reg.beat_s[1]) begin
      c_next.idle_cnt = '0;
      c_next.low_power = 1'b0;
    end else if (c_reg.idle_cnt == STOP_LAST) begin
      c_next.low_power = 1'b1; // R7
    end else begin
      c_next.idle_cnt = c_reg.idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      c_reg <= '0; // R2
    end else begin
      c_reg <= c_next;
    end
  end

  always_comb begin
    logic rise;
    logic in_tol;
    logic left_slot;
    rise = 1'b0;
    in_tol = 1'b0;
    left_slot = 1'b0;
    l_next = l_reg;
    l_next.fmt_s = {l_reg.fmt_s[0], format_select};
    l_next.bclk_s = {l_reg.bclk_s[1:0], link.bclk};
    l_next.lr_s = {l_reg.lr_s[1:0], link.lrclk};
    l_next.req_s = {l_reg.req_s[1:0], c_reg.req};
    l_next.beat = ~l_reg.beat;
    // act one cycle after the fall so the frame clock has settled
    l_next.fall_d = l_reg.bclk_s[2] & ~l_reg.bclk_s[1];
    // new sample pair from core, held stable until acknowledged
    if (l_reg.req_s[2] != l_reg.req_s[1]) begin
      l_next.pair = c_reg.y;
      l_next.ack = l_reg.req_s[1];
    end
    // R4 R3
    rise = l_reg.lr_s[1] & ~l_reg.lr_s[2];
    if (rise) begin
      for (int i = 0; i < 4; i++) begin
        if (l_reg.frame_cnt >= MCLK_RATIOS[i] - RATIO_TOL
            && l_reg.frame_cnt <= MCLK_RATIOS[i] + RATIO_TOL) begin
          in_tol = 1'b1;
        end
      end
      l_next.ratio_ok = in_tol; // R5
      l_next.frame_cnt = RATIO_W'(1);
    end else if (l_reg.frame_cnt != RATIO_MAX) begin
      l_next.frame_cnt = l_reg.frame_cnt + 1'b1;
    end
    if (l_reg.fall_d) begin
      l_next.lr_prev = l_reg.lr_s[1];
      // R5
      if (l_reg.ratio_ok) begin
        if (l_reg.lr_s[1] != l_reg.lr_prev) begin
          // R14 R16 R12
          left_slot = (l_reg.fmt_s[1] == FMT_LJ) ? l_reg.lr_s[1] : ~l_reg.lr_s[1];
          if (l_reg.fmt_s[1] == FMT_LJ) begin
            l_next.sdo = l_reg.pair[left_slot ? 0 : 1][SAMPLE_W-1]; // R13 R10
            l_next.word = {l_reg.pair[left_slot ? 0 : 1][SAMPLE_W-2:0], 1'b0};
          end else begin
            l_next.sdo = 1'b0; // R15 R10
            l_next.word = l_reg.pair[left_slot ? 0 : 1];
          end
        end else begin
          // R11 R18
          l_next.sdo = l_reg.word[SAMPLE_W-1];
          l_next.word = {l_reg.word[SAMPLE_W-2:0], 1'b0};
        end
      end
    end
    if (!l_reg.rst_s[1]) begin
      l_next = '0; // R2
      l_next.fmt_s = {l_reg.fmt_s[0], format_select};
      l_next.bclk_s = {l_reg.bclk_s[1:0], link.bclk};
      l_next.lr_s = {l_reg.lr_s[1:0], link.lrclk};
      l_next.req_s = {l_reg.req_s[1:0], c_reg.req};
    end
    l_next.rst_s = {l_reg.rst_s[0], nrst};
  end

  always_ff @(posedge link.audio_mclk) begin
    l_reg <= l_next;
  end

  assign link.serial_sample_out = l_reg.sdo;
  assign sample_ready = c_reg.ready & ~busy;
  assign power_good_n = c_reg.ready;
  assign ref_power_down = c_reg.low_power;
  assign ratio_error = ~c_reg.ok_s[1];
endmodule

// *** tb/sao_link_asserts.sv ***
`timescale 1ns/1ns
module sao_link_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic audio_mclk,
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic serial_sample_out,
  input wire logic format_select,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic power_good_n,
  input wire logic ref_power_down,
  input wire logic ratio_error
);
  logic [5:0] bit_reg;
  logic [9:0] stop_reg;
  logic [11:0] fmt_reg;
  logic [11:0] run_reg;
  logic pad;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // slot bit index, idle audio clock time, format settle time
  always_ff @(posedge mclk) begin
    if (!nrst || $changed(lrclk)) bit_reg <= 6'h00;
    else if ($rose(bclk)) bit_reg <= bit_reg + 6'h01;
    if (!nrst || $changed(audio_mclk)) stop_reg <= 10'h000;
    else if (stop_reg != 10'h3FF) stop_reg <= stop_reg + 10'h001;
    if (!nrst || $changed(format_select)) fmt_reg <= 12'h000;
    else if (fmt_reg != 12'hFFF) fmt_reg <= fmt_reg + 12'h001;
    if (!nrst || stop_reg != 10'h000) run_reg <= 12'h000;
    else if (run_reg != 12'hFFF) run_reg <= run_reg + 12'h001;
  end
  assign pad = format_select ? (bit_reg >= 6'h18) : (bit_reg == 6'h00 || bit_reg >= 6'h19);
  chk_reset_ready: assert property ($rose(nrst) |-> ##[0:2] power_good_n)
    else $error("ready flag late after reset");
  chk_ready_gate: assert property (sample_ready |-> power_good_n)
    else $error("sample taken before ready");
  chk_take_drop: assert property (sample_valid && sample_ready |=> !sample_ready)
    else $error("ready did not drop after take");
  chk_lr_on_fall: assert property ($changed(lrclk) && fmt_reg != 12'h000 && $past(nrst, 2)
    |-> $fell(bclk))
    else $error("frame clock moved off a bit clock fall");
  chk_slot_pad: assert property ($rose(bclk) && pad && !ratio_error && fmt_reg == 12'hFFF
    && run_reg == 12'hFFF
    |-> ##2 !serial_sample_out)
    else $error("slot padding bit not low");
  chk_frozen_out: assert property ($rose(serial_sample_out) |-> ##[0:8] !ratio_error)
    else $error("data moved while ratio bad");
  chk_stop_late: assert property ($rose(ref_power_down) |-> stop_reg >= 10'h0F5)
    else $error("low power entered too early");
  chk_stop_enter: assert property (stop_reg == 10'h12C |-> ##[0:8] ref_power_down)
    else $error("low power not entered");
  cover property ($rose(ref_power_down));
  cover property ($fell(ratio_error));
  cover property (sample_valid && sample_ready);
endmodule

// *** tb/stereo_adc_serial_output_bench.sv ***
`timescale 1ns/1ns
module stereo_adc_serial_output_bench;
  import sao_pkg::*;
  typedef struct packed {
    logic fmt;
    logic [SAMPLE_W-1:0] l;
    logic [SAMPLE_W-1:0] r;
  } sao_row_s;
  logic mclk, nrst, hpf_bypass_sel, format_select, audio_clk_run, sample_valid;
  logic sample_ready, power_good_n, ref_power_down, ratio_error, rx_valid;
  logic [SAMPLE_W-1:0] sample_left, sample_right, rx_left, rx_right;
  int n_mismatch = 0;
  int check_count = 0;
  sao_row_s rows [4] = '{'{FMT_LJ, 24'h800001, 24'h7FFFFE}, '{FMT_I2S, 24'h800001, 24'h7FFFFE},
    '{FMT_I2S, 24'h123456, 24'hFEDCBA}, '{FMT_LJ, 24'h7FFFFF, 24'h800000}};
  sao_if link_if();
  sao_rx sao_rx_inst (.mclk, .nrst, .link(link_if.rcv), .audio_clk_run, .format_select,
    .rx_left, .rx_right, .rx_valid);
  sao_adc_out sao_adc_out_inst (.mclk, .nrst, .link(link_if.dev), .hpf_bypass_sel,
    .format_select, .sample_valid, .sample_left, .sample_right, .sample_ready, .power_good_n,
    .ref_power_down, .ratio_error);
  sao_link_asserts sao_link_asserts_inst (.mclk, .nrst, .audio_mclk(link_if.audio_mclk),
    .bclk(link_if.bclk), .lrclk(link_if.lrclk), .serial_sample_out(link_if.serial_sample_out),
    .format_select, .sample_valid, .sample_ready, .power_good_n, .ref_power_down, .ratio_error);
  task automatic fail(input string msg);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic chk_word(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
    check_count++;
    if (got !== exp) fail("sample word mismatch");
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) fail("flag or wire bit mismatch");
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_rx(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 9000) begin
      @(negedge mclk);
      n++;
      if (rx_valid === 1'b1) k--;
    end
    if (k > 0) fail("no frame received");
  endtask
  task automatic send(input logic f, input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    format_select <= f;
    sample_valid <= 1'b1;
    sample_left <= l;
    sample_right <= r;
    do @(negedge mclk); while (sample_ready !== 1'b1 && ++n < 4000);
    @(posedge mclk);
    sample_valid <= 1'b0;
    wait_rx(4);
  endtask
  // left slot msb as the receiver samples it on the wire
  task automatic wire_msb(input logic lv, input int skip, input logic exp);
    int n;
    n = 0;
    while (link_if.lrclk === lv && n++ < 4000) @(negedge mclk);
    while (link_if.lrclk !== lv && n++ < 8000) @(negedge mclk);
    repeat (skip + 1) @(posedge link_if.bclk);
    repeat (SYNC_LAT) @(negedge mclk);
    chk_bit(link_if.serial_sample_out, exp);
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    fail("watchdog expired");
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    hpf_bypass_sel = 1'b1;
    format_select = FMT_LJ;
    audio_clk_run = 1'b0;
    sample_valid = 1'b0;
    sample_left = '0;
    sample_right = '0;
    repeat (2) @(posedge mclk);
    audio_clk_run <= 1'b1;
    repeat (12) @(negedge mclk);
    chk_bit(power_good_n, 1'b0);
    chk_bit(sample_ready, 1'b0);
    chk_bit(ratio_error, 1'b1);
    @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      send(rows[i].fmt, rows[i].l, rows[i].r);
      chk_word(rx_left, rows[i].l);
      chk_word(rx_right, rows[i].r);
      wire_msb(rows[i].fmt, rows[i].fmt ? 0 : 1, rows[i].l[SAMPLE_W-1]);
    end
    @(posedge mclk);
    hpf_bypass_sel <= HPF_ON;
    repeat (4) @(posedge mclk);
    send(FMT_LJ, 24'h400000, 24'h400000);
    chk_word(rx_left, 24'h3FF001);
    chk_word(rx_right, 24'h401000);
    send(FMT_LJ, 24'h400000, 24'h400000);
    chk_word(rx_left, 24'h3FE803);
    @(posedge mclk);
    hpf_bypass_sel <= 1'b1;
    audio_clk_run <= 1'b0;
    repeat (400) @(negedge mclk);
    chk_bit(ref_power_down, 1'b1);
    @(posedge mclk);
    audio_clk_run <= 1'b1;
    wait_rx(4);
    send(FMT_I2S, 24'h0F0F0F, 24'hF0F0F0);
    chk_word(rx_left, 24'h0F0F0F);
    chk_bit(ref_power_down, 1'b0);
    chk_bit(ratio_error, 1'b0);
    wrap_up();
  end
endmodule
